// File: core/ldc_core.sv
// Serial command interpreter, PWM data loader and PWM engine of a 16-channel LED sink driver.
// Assumes all serial pins and the grayscale reference clock are asynchronous to clk.
`timescale 1ns/100ps

module ldc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and control.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Fill side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] fill;
  logic doPush;
  logic doPop;

  assign inReady = (fill != (AW + 1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady && clkEn;
  assign doPop = outValid && outReady && clkEn;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      fill <= fill + (AW + 1)'(doPush) - (AW + 1)'(doPop);
    end
  end
endmodule

module ldc_core
  import ldc_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Serial command pins.
  input wire logic serialIn,
  input wire logic shiftClock,
  input wire logic commandStrobe,
  output logic serialOut,
  // Grayscale reference clock pin.
  input wire logic grayscaleRefClock,
  // Channel drive, high means the sink is on.
  output logic [CHANNELS-1:0] sinkChannel,
  // Settings for the analog section.
  output logic [15:0] gainHundredths,
  output logic thermalShutdownEnable,
  output logic openDetectEnable,
  output logic shortDetectEnable,
  output logic shortLevelTwo,
  output logic lowPower,
  output logic wakeBusy
);
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_WORD_LOAD = 3'b001,
    CMD_LOAD_START = 3'b010,
    CMD_FIRST_STATE = 3'b011,
    CMD_SECOND_STATE = 3'b100
  } ldc_cmd_t;

  // Fixed stagger order: position of each channel in the switching sequence.
  function automatic logic [3:0] orderPos(input int ch);
    case (ch)
      0: orderPos = 4'h0;  15: orderPos = 4'h1;  7: orderPos = 4'h2;  8: orderPos = 4'h3;
      1: orderPos = 4'h4;  14: orderPos = 4'h5;  6: orderPos = 4'h6;  9: orderPos = 4'h7;
      2: orderPos = 4'h8;  13: orderPos = 4'h9;  5: orderPos = 4'hA;  10: orderPos = 4'hB;
      3: orderPos = 4'hC;  12: orderPos = 4'hD;  4: orderPos = 4'hE;  default: orderPos = 4'hF;
    endcase
  endfunction

  // Mask of counter bits in use for a resolution code.
  function automatic logic [15:0] resMask(input logic [1:0] res);
    case (res)
      2'h0: resMask = 16'hFFFF;
      2'h1: resMask = 16'h3FFF;
      2'h2: resMask = 16'h0FFF;
      default: resMask = 16'h03FF;
    endcase
  endfunction

  // Slot position of a count in division mode: low seven bits pick the segment.
  function automatic logic [15:0] divPos(input logic [15:0] c, input logic [1:0] res);
    case (res)
      2'h0: divPos = {c[DIV_BITS-1:0], c[15:DIV_BITS]};
      2'h1: divPos = {2'h0, c[DIV_BITS-1:0], c[13:DIV_BITS]};
      2'h2: divPos = {4'h0, c[DIV_BITS-1:0], c[11:DIV_BITS]};
      default: divPos = {6'h0, c[DIV_BITS-1:0], c[9:DIV_BITS]};
    endcase
  endfunction

  // Two-flop synchronisers for the four pins, plus a third stage for edges.
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] syncC;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else if (clkEn) begin
      syncA <= {grayscaleRefClock, commandStrobe, shiftClock, serialIn};
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  logic sckRise;
  logic sckFall;
  logic strobeFall;
  logic refRise;
  assign sckRise = syncB[1] && !syncC[1];
  assign sckFall = !syncB[1] && syncC[1];
  assign strobeFall = !syncB[2] && syncC[2];
  assign refRise = syncB[3] && !syncC[3];

  logic initPulse;
  logic softRst;
  assign softRst = !rst_n || initPulse;

  // Shift register and strobe-high pulse counter.
  logic [WORD_W-1:0] shiftReg;
  logic [4:0] pulseCnt;
  logic [15:0] firstState;
  logic [15:0] secondState;
  always_ff @(posedge clk) begin
    if (softRst) begin
      shiftReg <= '0;
      pulseCnt <= '0;
    end else if (clkEn) begin
      if (sckRise && !syncB[2]) begin
        shiftReg <= {shiftReg[WORD_W-2:0], syncB[0]};
      end
      if (strobeFall) begin
        pulseCnt <= '0;
      end else if (sckRise && syncB[2] && pulseCnt != 5'h1F) begin
        pulseCnt <= pulseCnt + 5'h01;
      end
    end
  end

  // Serial output follows the shift register MSB on the chosen edge.
  always_ff @(posedge clk) begin
    if (softRst) begin
      serialOut <= 1'b0;
    end else if (clkEn) begin
      if (secondState[OUT_EDGE_POS] ? sckFall : sckRise) begin
        serialOut <= shiftReg[WORD_W-1];
      end
    end
  end

  ldc_cmd_t cmdCode;
  always_comb begin
    cmdCode = CMD_NONE;
    if (strobeFall) begin
      if (pulseCnt != 5'h00 && pulseCnt <= CNT_WORD_LOAD_MAX) begin
        cmdCode = CMD_WORD_LOAD;
      end else if (pulseCnt > CNT_WORD_LOAD_MAX && pulseCnt <= CNT_LOAD_START_MAX) begin
        cmdCode = CMD_LOAD_START;
      end else if (pulseCnt >= CNT_FIRST_STATE_MIN && pulseCnt <= CNT_FIRST_STATE_MAX) begin
        cmdCode = CMD_FIRST_STATE;
      end else if (pulseCnt >= CNT_SECOND_STATE_MIN && pulseCnt <= CNT_SECOND_STATE_MAX) begin
        cmdCode = CMD_SECOND_STATE;
      end
    end
  end

  // State-setting registers; the init bit itself is never stored.
  always_ff @(posedge clk) begin
    if (softRst) begin
      firstState <= FIRST_STATE_RESET;
      secondState <= SECOND_STATE_RESET;
      initPulse <= 1'b0;
    end else if (clkEn) begin
      initPulse <= (cmdCode == CMD_FIRST_STATE) && shiftReg[INIT_POS];
      if (cmdCode == CMD_FIRST_STATE) begin
        firstState <= shiftReg & ~(16'h0001 << INIT_POS);
      end
      if (cmdCode == CMD_SECOND_STATE) begin
        secondState <= shiftReg;
      end
    end
  end

  logic [31:0] gainProd;
  assign gainProd = {25'h0, firstState[GAIN_CODE_LSB +: 7]}
                    * (firstState[GAIN_RANGE_POS] ? {16'h0, LOW_GAIN_SPAN} : {16'h0, HIGH_GAIN_SPAN});
  always_ff @(posedge clk) begin
    if (softRst) begin
      gainHundredths <= '0;
    end else if (clkEn) begin
      gainHundredths <= (firstState[GAIN_RANGE_POS] ? LOW_GAIN_MIN : HIGH_GAIN_MIN)
                        + 16'(gainProd / {16'h0, GAIN_CODE_TOP});
    end
  end

  assign thermalShutdownEnable = !secondState[THERMAL_OFF_POS];
  assign openDetectEnable = secondState[OPEN_ON_POS];
  assign shortDetectEnable = secondState[SHORT_ON_POS];
  assign shortLevelTwo = secondState[SHORT_LEVEL_POS];

  // PWM words queue up; the last flag marks a load-and-start.
  logic pushValid;
  logic pushReady;
  logic [WORD_W:0] pushWord;
  logic popValid;
  logic popReady;
  logic [WORD_W:0] popWord;
  always_ff @(posedge clk) begin
    if (softRst) begin
      pushValid <= 1'b0;
      pushWord <= '0;
    end else if (clkEn) begin
      if ((cmdCode == CMD_WORD_LOAD || cmdCode == CMD_LOAD_START) && !pushValid) begin
        pushValid <= 1'b1;
        pushWord <= {cmdCode == CMD_LOAD_START, shiftReg};
      end else if (pushReady) begin
        pushValid <= 1'b0;
      end
    end
  end

  ldc_fifo #(.WIDTH(WORD_W + 1), .DEPTH(FIFO_DEPTH)) wordQueue (
    .clk(clk),
    .rst_n(!softRst),
    .clkEn(clkEn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popWord)
  );

  // Channel data registers, filled in channel order.
  logic [15:0] pwmData [CHANNELS];
  logic [15:0] activeData [CHANNELS];
  logic [3:0] loadIdx;
  logic startPending;
  logic running;
  logic periodDone;
  logic startGo;
  logic [15:0] pwmCount;
  // Loading stalls while a start waits, so a pending start keeps its data.
  assign popReady = !startPending;
  always_ff @(posedge clk) begin
    if (softRst) begin
      loadIdx <= '0;
      startPending <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        pwmData[i] <= '0;
      end
    end else if (clkEn) begin
      if (popValid && popReady) begin
        pwmData[loadIdx] <= popWord[WORD_W-1:0];
        loadIdx <= popWord[WORD_W] ? 4'h0 : loadIdx + 4'h1;
        startPending <= popWord[WORD_W];
      end else if (startGo) begin
        startPending <= 1'b0;
      end
    end
  end

  // Sync waits for period end, async restarts at once.
  assign periodDone = running && refRise && (pwmCount == resMask(firstState[RES_LSB +: 2]));
  assign startGo = startPending && (!running || secondState[ASYNC_POS] || periodDone);

  always_ff @(posedge clk) begin
    if (softRst) begin
      running <= 1'b0;
      pwmCount <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        activeData[i] <= '0;
      end
    end else if (clkEn) begin
      if (startGo) begin
        running <= 1'b1;
        pwmCount <= '0;
        activeData <= pwmData;
      end else if (periodDone) begin
        running <= 1'b0;
      end else if (running && refRise) begin
        pwmCount <= pwmCount + 16'h0001;
      end
    end
  end

  logic [15:0] slotPos;
  logic [CHANNELS-1:0] rawOn;
  always_comb begin
    slotPos = secondState[DIVIDED_POS] ? divPos(pwmCount, firstState[RES_LSB +: 2])
                                       : (pwmCount & resMask(firstState[RES_LSB +: 2]));
    for (int i = 0; i < CHANNELS; i++) begin
      rawOn[i] = running && (slotPos < (activeData[i] & resMask(firstState[RES_LSB +: 2])));
    end
  end

  logic refSeen;
  logic forcedOff;
  logic [31:0] lossCnt;
  always_ff @(posedge clk) begin
    if (softRst) begin
      refSeen <= 1'b0;
      forcedOff <= 1'b0;
      lossCnt <= '0;
    end else if (clkEn) begin
      if (refRise) begin
        refSeen <= 1'b1;
        forcedOff <= 1'b0;
        lossCnt <= '0;
      end else if (refSeen && !secondState[LOSS_OFF_POS]) begin
        if (lossCnt >= 32'(LOSS_LIMIT - 1)) begin
          forcedOff <= 1'b1;
        end else begin
          lossCnt <= lossCnt + 32'h1;
        end
      end else begin
        forcedOff <= 1'b0;
        lossCnt <= '0;
      end
    end
  end

  // Staggered channel switching in fixed order.
  logic [3:0] stagger;
  always_ff @(posedge clk) begin
    if (softRst) begin
      stagger <= '0;
      sinkChannel <= '0;
    end else if (clkEn) begin
      stagger <= stagger + 4'h1;
      for (int i = 0; i < CHANNELS; i++) begin
        if (forcedOff) begin
          sinkChannel[i] <= 1'b0;
        end else if (secondState[DELAY_OFF_POS] || stagger == orderPos(i)) begin
          sinkChannel[i] <= rawOn[i] && !lowPower;
        end
      end
    end
  end

  // Standby one ends on a word load; standby two follows data registers one and three.
  logic standbyOne;
  logic standbyTwo;
  logic [10:0] wakeCnt;
  always_ff @(posedge clk) begin
    if (softRst) begin
      standbyOne <= 1'b0;
      standbyTwo <= 1'b0;
      lowPower <= 1'b0;
      wakeCnt <= '0;
      wakeBusy <= 1'b0;
    end else if (clkEn) begin
      if (cmdCode == CMD_FIRST_STATE && shiftReg[STANDBY1_POS]) begin
        standbyOne <= 1'b1;
      end else if (cmdCode == CMD_WORD_LOAD) begin
        standbyOne <= 1'b0;
      end
      standbyTwo <= secondState[STANDBY2_POS] && firstState[RES_LSB +: 2] == RES_16
                    && pwmData[1] == '0 && pwmData[3] == '0;
      lowPower <= standbyOne || standbyTwo;
      if (lowPower && !(standbyOne || standbyTwo)) begin
        wakeBusy <= 1'b1;
        wakeCnt <= 11'(WAKE_CYCLES - 1);
      end else if (wakeCnt != '0) begin
        wakeCnt <= wakeCnt - 11'h001;
      end else begin
        wakeBusy <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_second_word_copy: assert property ((clkEn && cmdCode == CMD_SECOND_STATE && !initPulse)
    |=> secondState == $past(shiftReg)) else $error("second word not copied");
  a_init_defaults: assert property ((clkEn && initPulse)
    |=> firstState == FIRST_STATE_RESET && secondState == SECOND_STATE_RESET && !running)
    else $error("init did not restore defaults");
  a_one_period_only: assert property ((clkEn && periodDone && !startPending)
    |=> !running) else $error("period repeated without start");
  a_async_restart: assert property ((clkEn && startPending && secondState[ASYNC_POS]
    && !initPulse) |=> running && pwmCount == '0) else $error("async start not immediate");
  a_sync_waits: assert property ((clkEn && startPending && running && !secondState[ASYNC_POS]
    && !periodDone && !initPulse) |=> startPending) else $error("sync start cut period");
  a_loss_forces_off: assert property ((clkEn && forcedOff && !initPulse)
    |=> sinkChannel == '0) else $error("outputs on during clock loss");
  a_wake_hold: assert property ($rose(wakeBusy) |-> wakeBusy[*8])
    else $error("wake time too short");
  a_thermal_map: assert property ((clkEn && cmdCode == CMD_SECOND_STATE && !initPulse)
    |=> thermalShutdownEnable == !$past(shiftReg[THERMAL_OFF_POS]))
    else $error("thermal control inverted");
  c_load_start: cover property (startGo && !running);
  c_sync_queued: cover property (startPending && running && !secondState[ASYNC_POS]);
  c_clock_loss: cover property ($rose(forcedOff));
endmodule

// File: include/ldc_pkg.sv
// Shared constants of the LED driver command interpreter.
// Assumes a 40 MHz system clock and a 16-bit serial command word.
package ldc_pkg;
  localparam int WORD_W = 16;
  localparam int CHANNELS = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ = 40000000;
  // Wake time from both standby modes, in ns, and its cycle count rounded up.
  localparam int WAKE_TIME_NS = 30000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reference clock loss time, in seconds.
  localparam int LOSS_TIME_S = 1;
  localparam int LOSS_CYCLES = LOSS_TIME_S * CLK_HZ;
  // Command codes: strobe-high shift clock pulse counts, pairs of two.
  localparam logic [4:0] CNT_WORD_LOAD_MAX = 5'h02;
  localparam logic [4:0] CNT_LOAD_START_MAX = 5'h04;
  localparam logic [4:0] CNT_FIRST_STATE_MIN = 5'h0D;
  localparam logic [4:0] CNT_FIRST_STATE_MAX = 5'h0E;
  localparam logic [4:0] CNT_SECOND_STATE_MIN = 5'h0F;
  localparam logic [4:0] CNT_SECOND_STATE_MAX = 5'h10;
  // Field positions of the first setting word.
  localparam int GAIN_RANGE_POS = 15;
  localparam int GAIN_CODE_LSB = 8;
  localparam int RES_LSB = 2;
  localparam int INIT_POS = 1;
  localparam int STANDBY1_POS = 0;
  // Field positions of the second setting word.
  localparam int THERMAL_OFF_POS = 15;
  localparam int LOSS_OFF_POS = 14;
  localparam int OPEN_ON_POS = 13;
  localparam int SHORT_ON_POS = 12;
  localparam int ASYNC_POS = 11;
  localparam int DIVIDED_POS = 10;
  localparam int STANDBY2_POS = 9;
  localparam int SHORT_LEVEL_POS = 8;
  localparam int DELAY_OFF_POS = 7;
  localparam int OUT_EDGE_POS = 6;
  // Reset values: gain code 43 is 100 percent in the high range.
  localparam logic [15:0] FIRST_STATE_RESET = 16'h2B00;
  localparam logic [15:0] SECOND_STATE_RESET = 16'h0000;
  localparam logic [1:0] RES_16 = 2'h0;
  // Gain in hundredths of a percent: low end and span of each range.
  localparam logic [15:0] LOW_GAIN_MIN = 16'h034E;
  localparam logic [15:0] LOW_GAIN_SPAN = 16'h0DDE;
  localparam logic [15:0] HIGH_GAIN_MIN = 16'h128E;
  localparam logic [15:0] HIGH_GAIN_SPAN = 16'h3CA0;
  localparam logic [15:0] GAIN_CODE_TOP = 16'h007F;
  // Division mode splits a period into 128 segments.
  localparam int DIV_BITS = 7;
endpackage

// File: test/ldc_host.sv
// Host controller model that drives the serial command pins of the LED driver.
// Assumes the device samples these pins with its own clock; pins change at falling edges.
`timescale 1ns/100ps

module ldc_host (
  // Clock used only to pace the pins.
  input wire logic clk,
  // Serial command pins.
  output logic serialIn,
  output logic shiftClock,
  output logic commandStrobe
);
  initial begin
    serialIn = 1'b0;
    shiftClock = 1'b0;
    commandStrobe = 1'b0;
  end

  // One shift clock pulse, 100 ns low then 100 ns high; the clock stands low between frames.
  task automatic pulse();
    repeat (4) @(negedge clk);
    shiftClock = 1'b1;
    repeat (4) @(negedge clk);
    shiftClock = 1'b0;
  endtask

  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      serialIn = w[i];
      pulse();
    end
    @(negedge clk);
    serialIn = ~serialIn;
  endtask

  task automatic command(input int pulses);
    @(negedge clk);
    commandStrobe = 1'b1;
    repeat (pulses) pulse();
    repeat (4) @(negedge clk);
    commandStrobe = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule

// File: test/led_driver_config_and_pwm_load_bench.sv
// Self-checking bench of the LED driver command interpreter and PWM loader.
// Assumes the host model in ldc_host drives the serial pins; the bench makes the reference clock.
`timescale 1ns/100ps

module led_driver_config_and_pwm_load_bench import ldc_pkg::*;;
  `define CHECK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin errors++; $display("wrong value at %0t: %s", $time, msg); end end

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic grayscaleRefClock = 1'b0;
  logic refRun = 1'b1;
  logic clkEnable = 1'b1;
  logic [2:0] refDiv = 3'h0;
  logic serialIn, shiftClock, commandStrobe, serialOut;
  logic [CHANNELS-1:0] sinkChannel, expMask;
  logic [15:0] gainHundredths, firstW, secondW, d;
  logic thermalShutdownEnable, openDetectEnable, shortDetectEnable, shortLevelTwo;
  logic lowPower, wakeBusy;
  int errors = 0;
  int n_compared = 0;
  int k, bad;
  int cnts[8] = '{15, 16, 11, 16, 15, 5, 15, 12};

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Reference clock of 200 ns, stopped only to provoke the loss detector.
  always @(negedge clk) begin
    if (refRun) begin
      refDiv <= refDiv + 3'h1;
      if (refDiv == 3'h3) begin
        refDiv <= 3'h0;
        grayscaleRefClock <= ~grayscaleRefClock;
      end
    end
  end

  ldc_host host (.clk(clk), .serialIn(serialIn), .shiftClock(shiftClock),
    .commandStrobe(commandStrobe));

  ldc_core #(.LOSS_LIMIT(2000)) dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEnable),
    .serialIn(serialIn), .shiftClock(shiftClock), .commandStrobe(commandStrobe),
    .serialOut(serialOut), .grayscaleRefClock(grayscaleRefClock), .sinkChannel(sinkChannel),
    .gainHundredths(gainHundredths), .thermalShutdownEnable(thermalShutdownEnable),
    .openDetectEnable(openDetectEnable), .shortDetectEnable(shortDetectEnable),
    .shortLevelTwo(shortLevelTwo), .lowPower(lowPower), .wakeBusy(wakeBusy));

  // Gain in hundredths of a percent, linear between the range ends.
  function automatic logic [15:0] gain(input logic [15:0] w);
    int code;
    code = w[14:8];
    if (w[15]) return 16'(846 + code * 3550 / 127);
    return 16'(4750 + code * 15520 / 127);
  endfunction

  task automatic first(input logic [15:0] w);
    host.send_word(w);
    host.command(13);
    if (w[1]) begin
      firstW = 16'h2B00;
      secondW = 16'h0000;
    end else begin
      firstW = w;
    end
  endtask

  task automatic second(input logic [15:0] w, input int cnt);
    host.send_word(w);
    host.command(cnt);
    if (cnt == 15 || cnt == 16) secondW = w;
  endtask

  task automatic check_settings();
    `CHECK(gainHundredths, gain(firstW), "gain")
    `CHECK(thermalShutdownEnable, ~secondW[15], "thermal")
    `CHECK(openDetectEnable, secondW[13], "open detect")
    `CHECK(shortDetectEnable, secondW[12], "short detect")
    `CHECK(shortLevelTwo, secondW[8], "short level")
  endtask

  task automatic wait_bound(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("wrong value at %0t: wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(30));
    firstW = 16'h2B00;
    secondW = 16'h0000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check_settings();
    `CHECK(lowPower, 1'b0, "low power at reset")
    // A frozen block must ignore a whole command, init bit included.
    clkEnable = 1'b0;
    host.send_word(16'hFFFF);
    host.command(13);
    clkEnable = 1'b1;
    repeat (4) @(negedge clk);
    check_settings();
    `CHECK(serialOut, 1'b0, "serial out moved while frozen")
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = {i[0], (i < 2) ? 7'h00 : (i < 4) ? 7'h7F : 7'($urandom), 8'h00};
      first(d);
      check_settings();
    end
    $display("test gain done");
    // Counts 5, 11 and 12 change nothing.
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom) & 16'hFDC0;
      second(d, cnts[i]);
      check_settings();
      `CHECK(serialOut, d[15], "serial out")
    end
    first(16'h2B02);
    check_settings();
    $display("test second word and init done");
    second(16'h0200, 15);
    `CHECK(lowPower, 1'b1, "standby two")
    first(16'h2B04);
    `CHECK(lowPower, 1'b0, "standby two needs 16 bit")
    second(16'h0000, 16);
    first(16'h2B01);
    `CHECK(lowPower, 1'b1, "standby one")
    host.send_word(16'h1234);
    host.command(1);
    `CHECK(lowPower, 1'b0, "standby one ends on load")
    for (k = 0; k < 1400 && wakeBusy === 1'b1; k++) @(negedge clk);
    wait_bound(k, 1400);
    `CHECK(k > 30000 / 25 - 100 && k <= 30000 / 25 + 1, 1'b1, "wake time")
    first(16'h2B02);
    $display("test standby done");
    // Speed load of 10-bit data, 15 loads then load and start.
    first(16'h2B0C);
    for (int i = 0; i < 16; i++) begin
      d = ($urandom % 2 == 1 || i == 0) ? 16'h0300 : 16'h0000;
      expMask[i] = d[8];
      if (i == 15) `CHECK(sinkChannel, 16'h0000, "output before start")
      host.send_word(d);
      host.command(i == 15 ? 3 : 1);
    end
    for (k = 0; k < 400 && sinkChannel === 16'h0000; k++) @(negedge clk);
    wait_bound(k, 400);
    repeat (400) @(negedge clk);
    `CHECK(sinkChannel, expMask, "pwm on pattern")
    for (k = 0; k < 10000 && sinkChannel !== 16'h0000; k++) @(negedge clk);
    wait_bound(k, 10000);
    bad = 0;
    repeat (9000) begin
      @(negedge clk);
      if (sinkChannel !== 16'h0000) bad++;
    end
    `CHECK(bad, 0, "period repeated without start")
    $display("test pwm load done");
    host.send_word(16'h0300);
    host.command(3);
    for (k = 0; k < 400 && sinkChannel === 16'h0000; k++) @(negedge clk);
    wait_bound(k, 400);
    // A synchronous start with zero data must wait for the period end.
    host.send_word(16'h0000);
    host.command(3);
    repeat (100) @(negedge clk);
    `CHECK(sinkChannel[0], 1'b1, "sync start cut period")
    // Switching to asynchronous mode lets the pending start restart at once.
    second(16'h0800, 16);
    for (k = 0; k < 400 && sinkChannel[0] !== 1'b0; k++) @(negedge clk);
    wait_bound(k, 400);
    `CHECK(sinkChannel[0], 1'b0, "async start not immediate")
    $display("test start modes done");
    host.send_word(16'h0300);
    host.command(3);
    for (k = 0; k < 400 && sinkChannel[0] !== 1'b1; k++) @(negedge clk);
    wait_bound(k, 400);
    refRun = 1'b0;
    repeat (2100) @(negedge clk);
    `CHECK(sinkChannel, 16'h0000, "outputs on after clock loss")
    refRun = 1'b1;
    $display("test clock loss done");
    stop_test();
  end
endmodule
